// ==== seat_power_pkg.sv ====
// Contract
// - AC output codes: 01 enable, 10 disable
// - lamp code 01 forced on, 10 automatic
// - fan code 01 on, 10 auto, 11 off
// - indicator code 01 green, 10 red, 11 auto
// - DC output codes: 01 enable, 10 disable
// - policy message F4h, length 04h, tag 50 4D 53
// - policy 1 all on, 2 unused off, 3 off
// - transfer F6h, two-byte length 1 to 1025
// - transfer commands D1h D2h D3h D4h D8h
// - reject reply D5h plus error code 01h-05h
// - status reply DCh, 64 hex chars, 16-byte part
// - digest is one hash pass over memory
// - temperature query A5h answered A6h within 1 s
// - report length 06h, limits 3,4,1,2, timeout, temp; code sends limits_q bytes in order from [31:24] down to [7:0]
// - report fields are thresholds and shed interval
// - temperature is one two's-complement byte
// - outlet message F4h, 06h, 50 4F 53, three bytes
// - inhibit discrete always overrides outlet enables
//
// constants, types and register map of the seat power command handler;
// assumes a 20 MHz system clock and byte-wide message framing upstream
package seat_power_pkg;

   // message identifiers
   localparam logic [7:0]  PROTO_ID      = 8'h01;
   localparam logic [7:0]  CMD_CFG       = 8'hF4;
   localparam logic [7:0]  CMD_XFER      = 8'hF6;
   localparam logic [7:0]  CMD_TEMP_Q    = 8'hA5;
   localparam logic [7:0]  CMD_TEMP_R    = 8'hA6;
   localparam logic [7:0]  LEN_OUTLET    = 8'h06;
   localparam logic [7:0]  LEN_POLICY    = 8'h04;
   localparam logic [7:0]  LEN_TEMP      = 8'h06;
   localparam logic [23:0] TAG_OUTLET    = 24'h504F53;
   localparam logic [23:0] TAG_POLICY    = 24'h504D53;
   // transfer sub-protocol
   localparam logic [7:0]  XF_REQ        = 8'hD1;
   localparam logic [7:0]  XF_START      = 8'hD2;
   localparam logic [7:0]  XF_CHUNK      = 8'hD3;
   localparam logic [7:0]  XF_DONE       = 8'hD4;
   localparam logic [7:0]  XF_QUERY      = 8'hD8;
   localparam logic [7:0]  XF_REJECT     = 8'hD5;
   localparam logic [7:0]  XF_STAT_R     = 8'hDC;
   localparam logic [7:0]  ERR_MSG_SUM   = 8'h01;
   localparam logic [7:0]  ERR_SEQ       = 8'h02;
   localparam logic [7:0]  ERR_FLASH     = 8'h03;
   localparam logic [7:0]  ERR_PROG_SUM  = 8'h04;
   localparam logic [7:0]  ERR_COPROC    = 8'h05;
   localparam logic [15:0] XFER_LEN_MAX  = 16'h0401;   // 1025
   localparam logic [15:0] XFER_LEN_MIN  = 16'h0001;
   localparam logic [7:0]  REJECT_LEN    = 8'h02;
   localparam logic [7:0]  STATUS_LEN    = 8'h51;      // 81
   localparam logic [6:0]  TX_N_TEMP     = 7'h09;
   localparam logic [6:0]  TX_N_REJECT   = 7'h06;
   localparam logic [6:0]  TX_N_STATUS   = 7'h55;      // 4 header + 81
   localparam logic [6:0]  TX_DIGEST_POS = 7'h05;
   localparam logic [6:0]  TX_PART_POS   = 7'h45;      // 5 + 64
   // two-bit field codes
   localparam logic [1:0]  CODE_ON       = 2'h1;
   localparam logic [1:0]  CODE_OFF      = 2'h2;
   localparam logic [1:0]  CODE_THREE    = 2'h3;
   localparam logic [7:0]  POLICY_ALL    = 8'h01;
   localparam logic [7:0]  POLICY_UNUSED = 8'h02;
   localparam logic [7:0]  POLICY_NONE   = 8'h03;
   // register byte offsets
   localparam logic [4:0]  REG_LIMITS    = 5'h00;
   localparam logic [4:0]  REG_TIMEOUT   = 5'h04;
   localparam logic [4:0]  REG_TEMP      = 5'h08;
   localparam logic [4:0]  REG_OUTLETS   = 5'h0C;
   localparam logic [4:0]  REG_XFER      = 5'h10;
   localparam logic [31:0] LIMITS_RST    = 32'h0000_0000;
   localparam logic [7:0]  TIMEOUT_RST   = 8'h00;
   localparam logic [7:0]  TEMP_RST      = 8'h00;
   localparam logic [3:0]  OUTLET_RST    = 4'h0;
   // answer deadline
   localparam int unsigned CLK_HZ         = 20000000;
   localparam int unsigned RESP_LIMIT_MS  = 1000;
   localparam int unsigned RESP_LIMIT_DEF = CLK_HZ / 1000 * RESP_LIMIT_MS;
   localparam logic [127:0] PART_DEF      = 128'h504E2D30303030303030303030303031; // arbitrary

   typedef enum logic [1:0] {LAMP_AUTO, LAMP_ON} lamp_mode_e;
   typedef enum logic [1:0] {FAN_AUTO, FAN_ON, FAN_OFF} fan_mode_e;
   typedef enum logic [1:0] {IND_AUTO, IND_GREEN, IND_RED} ind_mode_e;
   typedef enum logic [1:0] {XS_IDLE, XS_ARMED, XS_LOADING, XS_FINAL} xfer_state_e;
   typedef enum logic [1:0] {TX_TEMP, TX_REJECT, TX_STATUS} tx_kind_e;
   localparam lamp_mode_e LAMP_RST = LAMP_AUTO;
   localparam fan_mode_e  FAN_RST  = FAN_AUTO;
   localparam ind_mode_e  IND_RST  = IND_AUTO;

   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] data;
   } byte_beat_s;

endpackage

// ==== seat_power_command_handler.sv ====
// seat power command handler: decodes outlet, policy, temperature and
// transfer messages, answers on a byte stream, registers over Avalon-MM;
// assumes framing and checksum checking upstream on the same clock
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module seat_power_command_handler
   import seat_power_pkg::*;
#(
   parameter int unsigned  RESP_LIMIT_CYC = RESP_LIMIT_DEF,
   parameter logic [127:0] PART_NUMBER    = PART_DEF
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_i,
   input  wire logic [4:0]   avm_address_i,
   input  wire logic         avm_read_i,
   input  wire logic         avm_write_i,
   input  wire logic [31:0]  avm_writedata_i,
   input  wire logic [3:0]   avm_byteenable_i,
   output logic [31:0]       avm_readdata_o,
   output logic              avm_waitrequest_o,
   input  wire byte_beat_s   rx_i,
   input  wire logic         rx_err_i,
   output byte_beat_s        tx_o,
   input  wire logic         tx_ready_i,
   input  wire logic         outlet_inhibit_i,
   input  wire logic [7:0]   outlet_in_use_i,
   output logic [3:0]        ac_out_o,
   output logic [3:0]        dc_out_o,
   output logic              lamp_force_on_o,
   output logic              fan_force_on_o,
   output logic              fan_disable_o,
   output logic              ind_green_o,
   output logic              ind_red_o,
   output byte_beat_s        image_chunk_o,
   input  wire logic         flash_fail_i,
   input  wire logic         prog_sum_bad_i,
   input  wire logic         coproc_fault_i,
   output logic              hash_req_o,
   input  wire logic         hash_done_i,
   input  wire logic [255:0] digest_i
);

   // applies four two-bit enable codes, byte order D, A, B, C
   function automatic logic [3:0] apply_en(input logic [3:0] cur, input logic [7:0] b);
      logic [1:0] f [4];
      logic [3:0] r;
      f[0] = b[5:4];
      f[1] = b[3:2];
      f[2] = b[1:0];
      f[3] = b[7:6];
      r = cur;
      for (int i = 0; i < 4; i++) begin
         if (f[i] == CODE_ON) r[i] = 1'b1;
         else if (f[i] == CODE_OFF) r[i] = 1'b0;
      end
      return r;
   endfunction

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'hA) ? 8'(8'h30 + n) : 8'(8'h37 + n);
   endfunction

   // pin synchronisers
   logic       inh_s1_q, inh_s2_q;
   logic [7:0] use_s1_q, use_s2_q;
   always_ff @(posedge clk_sys_i) begin
      inh_s1_q <= outlet_inhibit_i;
      inh_s2_q <= inh_s1_q;
      use_s1_q <= outlet_in_use_i;
      use_s2_q <= use_s1_q;
   end

   // receive parser state
   logic [10:0] idx_q;
   logic [7:0]  cmd_q, op_q;
   logic [15:0] len_q;
   logic [39:0] sh_q;
   logic        proto_ok_q;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         idx_q <= 11'h000;
      end else if (rx_i.valid) begin
         idx_q <= rx_i.last ? 11'h000 : ((idx_q == 11'h7FF) ? idx_q : 11'(idx_q + 11'h001));
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (rx_i.valid) begin
         sh_q <= {sh_q[31:0], rx_i.data};
         if (idx_q == 11'h000) proto_ok_q <= (rx_i.data == PROTO_ID);
         if (idx_q == 11'h001) cmd_q <= rx_i.data;
         if (idx_q == 11'h002) len_q[15:8] <= rx_i.data;
         if (idx_q == 11'h003) len_q[7:0] <= rx_i.data;
         if (idx_q == 11'h004) op_q <= rx_i.data;
      end
   end

   // message decode at the end of a frame
   wire        eof       = rx_i.valid && rx_i.last && !rx_err_i;
   wire        eof_any   = rx_i.valid && rx_i.last;
   wire [47:0] win       = {sh_q, rx_i.data};
   wire [7:0]  len8      = len_q[15:8];
   wire        cfg_frame = eof && proto_ok_q && cmd_q == CMD_CFG
                           && idx_q == 11'(11'h002 + {3'h0, len8});
   wire        do_outlet = cfg_frame && len8 == LEN_OUTLET && win[47:24] == TAG_OUTLET;
   wire        do_policy = cfg_frame && len8 == LEN_POLICY && win[31:8] == TAG_POLICY;
   wire        temp_hit  = eof && proto_ok_q && idx_q == 11'h001
                           && rx_i.data == CMD_TEMP_Q;
   wire        xf_frame  = eof_any && proto_ok_q && cmd_q == CMD_XFER
                           && idx_q >= 11'h004;
   wire [7:0]  xf_op     = (idx_q == 11'h004) ? rx_i.data : op_q;
   wire        xf_len_ok = len_q >= XFER_LEN_MIN && len_q <= XFER_LEN_MAX
                           && idx_q == 11'(len_q[10:0] + 11'h003);
   wire        xf_full   = len_q == XFER_LEN_MAX;

   // outlet and mode settings
   logic [3:0] ac_en_q, dc_en_q, ac_en_d, dc_en_d;
   lamp_mode_e lamp_q, lamp_d;
   fan_mode_e  fan_q, fan_d;
   ind_mode_e  ind_q, ind_d;
   wire [7:0]  cfg_b1 = win[23:16];
   wire [7:0]  cfg_b2 = win[15:8];
   wire [7:0]  cfg_b3 = win[7:0];
   // byte two: lamp [7:6], fan [5:4], zero spare [3:2], indicator [1:0]
   always_comb begin
      ac_en_d = ac_en_q;
      dc_en_d = dc_en_q;
      lamp_d  = lamp_q;
      fan_d   = fan_q;
      ind_d   = ind_q;
      if (do_outlet) begin
         ac_en_d = apply_en(ac_en_q, cfg_b1);
         dc_en_d = apply_en(dc_en_q, cfg_b3);
         if (cfg_b2[7:6] == CODE_ON) lamp_d = LAMP_ON;
         else if (cfg_b2[7:6] == CODE_OFF) lamp_d = LAMP_AUTO;
         case (cfg_b2[5:4])
            CODE_ON:    fan_d = FAN_ON;
            CODE_OFF:   fan_d = FAN_AUTO;
            CODE_THREE: fan_d = FAN_OFF;
            default:    fan_d = fan_q;
         endcase
         case (cfg_b2[1:0])
            CODE_ON:    ind_d = IND_GREEN;
            CODE_OFF:   ind_d = IND_RED;
            CODE_THREE: ind_d = IND_AUTO;
            default:    ind_d = ind_q;
         endcase
      end else if (do_policy) begin
         case (win[7:0])
            POLICY_ALL: begin
               ac_en_d = 4'hF;
               dc_en_d = 4'hF;
            end
            POLICY_UNUSED: begin
               ac_en_d = ac_en_q & use_s2_q[3:0];
               dc_en_d = dc_en_q & use_s2_q[7:4];
            end
            POLICY_NONE: begin
               ac_en_d = 4'h0;
               dc_en_d = 4'h0;
            end
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ac_en_q <= OUTLET_RST;
         dc_en_q <= OUTLET_RST;
         lamp_q  <= LAMP_RST;
         fan_q   <= FAN_RST;
         ind_q   <= IND_RST;
      end else begin
         ac_en_q <= ac_en_d;
         dc_en_q <= dc_en_d;
         lamp_q  <= lamp_d;
         fan_q   <= fan_d;
         ind_q   <= ind_d;
      end
   end
   // the inhibit discrete masks enables, stored settings survive it
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ac_out_o        <= 4'h0;
         dc_out_o        <= 4'h0;
         lamp_force_on_o <= 1'b0;
         fan_force_on_o  <= 1'b0;
         fan_disable_o   <= 1'b0;
         ind_green_o     <= 1'b0;
         ind_red_o       <= 1'b0;
      end else begin
         ac_out_o        <= ac_en_q & {4{!inh_s2_q}};
         dc_out_o        <= dc_en_q & {4{!inh_s2_q}};
         lamp_force_on_o <= lamp_q == LAMP_ON;
         fan_force_on_o  <= fan_q == FAN_ON;
         fan_disable_o   <= fan_q == FAN_OFF;
         ind_green_o     <= ind_q == IND_GREEN;
         ind_red_o       <= ind_q == IND_RED;
      end
   end

   // transfer sequence; coprocessor and flash faults ranked ahead of sequence errors, program checksum behind them
   xfer_state_e xs_q, xs_d;
   logic        reject_d, query_d, flash_bad_q;
   logic [7:0]  err_d;
   always_comb begin
      xs_d     = xs_q;
      reject_d = 1'b0;
      query_d  = 1'b0;
      err_d    = ERR_SEQ;
      if (xf_frame) begin
         if (rx_err_i || !xf_len_ok) begin
            err_d = ERR_MSG_SUM;
            reject_d = 1'b1;
         end else if (xf_op == XF_QUERY && idx_q == 11'h004) begin
            query_d = 1'b1;
         end else if (coproc_fault_i) begin
            err_d = ERR_COPROC;
            reject_d = 1'b1;
         end else if (flash_bad_q) begin
            err_d = ERR_FLASH;
            reject_d = 1'b1;
         end else begin
            case (xs_q)
               XS_IDLE: begin
                  reject_d = xf_op != XF_REQ || idx_q != 11'h004;
                  xs_d = XS_ARMED;
               end
               XS_ARMED: begin
                  reject_d = xf_op != XF_START || idx_q != 11'h004;
                  xs_d = XS_LOADING;
               end
               XS_LOADING: begin
                  if (xf_op == XF_CHUNK) xs_d = xf_full ? XS_LOADING : XS_FINAL;
                  else reject_d = xf_op != XF_DONE || idx_q != 11'h004;
                  if (xf_op == XF_DONE) xs_d = XS_IDLE;
               end
               XS_FINAL: begin
                  reject_d = xf_op != XF_DONE || idx_q != 11'h004;
                  xs_d = XS_IDLE;
               end
               default: xs_d = XS_IDLE;
            endcase
            if (!reject_d && xf_op == XF_DONE && prog_sum_bad_i) begin
               err_d = ERR_PROG_SUM;
               reject_d = 1'b1;
            end
         end
         if (reject_d) xs_d = XS_IDLE;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         xs_q        <= XS_IDLE;
         flash_bad_q <= 1'b0;
      end else begin
         xs_q        <= xs_d;
         flash_bad_q <= flash_fail_i || (flash_bad_q && !(xf_frame && reject_d));
      end
   end
   // image bytes stream straight to the flash writer, no buffering
   wire chunk_byte = rx_i.valid && proto_ok_q && cmd_q == CMD_XFER && idx_q >= 11'h005
                     && op_q == XF_CHUNK && xs_q == XS_LOADING;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) image_chunk_o <= '0;
      else image_chunk_o <= '{valid: chunk_byte, last: rx_i.last, data: rx_i.data};
   end

   // pending answers, digest fetch and deadline watchdog
   logic         p_temp_q, p_rej_q, p_stat_q, wait_hash_q, busy_q, late_q;
   logic [7:0]   rej_code_q;
   logic [255:0] digest_q;
   logic [31:0]  age_q;
   tx_kind_e     kind_q;
   logic [6:0]   tx_idx_q, tx_n_q;
   wire          tx_free   = !tx_o.valid || tx_ready_i;
   wire          expire    = age_q == 32'(RESP_LIMIT_CYC - 1);
   wire          start     = !busy_q && (p_rej_q || p_stat_q || p_temp_q) && !expire;
   wire          st_rej    = start && p_rej_q;
   wire          st_stat   = start && !p_rej_q && p_stat_q;
   wire          st_temp   = start && !p_rej_q && !p_stat_q;
   wire          got_hash  = wait_hash_q && hash_done_i;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || expire) begin
         p_temp_q    <= 1'b0;
         p_rej_q     <= 1'b0;
         p_stat_q    <= 1'b0;
         wait_hash_q <= 1'b0;
      end else begin
         p_temp_q    <= temp_hit || (p_temp_q && !st_temp);
         p_rej_q     <= (xf_frame && reject_d) || (p_rej_q && !st_rej);
         p_stat_q    <= got_hash || (p_stat_q && !st_stat);
         wait_hash_q <= query_d || (wait_hash_q && !hash_done_i);
      end
   end
   // one hash pass per status query, result sent as-is
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) hash_req_o <= 1'b0;
      else hash_req_o <= query_d;
      if (xf_frame && reject_d) rej_code_q <= err_d;
      if (got_hash) digest_q <= digest_i;
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !(busy_q || p_temp_q || p_rej_q || p_stat_q || wait_hash_q)) age_q <= '0;
      else age_q <= 32'(age_q + 32'h1);
   end

   // reply byte selection by kind and position
   logic [31:0] limits_q;
   logic [7:0]  timeout_q, temp_q, tx_byte;
   wire  [5:0]  dchr  = 6'(tx_idx_q - TX_DIGEST_POS);
   wire  [3:0]  pchr  = 4'(tx_idx_q - TX_PART_POS);
   wire  [7:0]  dbase = 8'(8'hFF - {dchr, 2'b00});
   wire  [6:0]  pbase = 7'(7'h7F - {pchr, 3'b000});
   wire  [2:0]  lsel  = 3'(tx_idx_q - 7'h03);
   always_comb begin
      tx_byte = 8'h00;
      case (kind_q)
         TX_TEMP: begin
            case (tx_idx_q)
               7'h00:   tx_byte = PROTO_ID;
               7'h01:   tx_byte = CMD_TEMP_R;
               7'h02:   tx_byte = LEN_TEMP;
               7'h07:   tx_byte = timeout_q;
               7'h08:   tx_byte = temp_q;
               default: tx_byte = limits_q[8'(8'h1F - {lsel, 3'b000}) -: 8];
            endcase
         end
         TX_REJECT: begin
            case (tx_idx_q)
               7'h00:   tx_byte = PROTO_ID;
               7'h01:   tx_byte = CMD_XFER;
               7'h02:   tx_byte = 8'h00;
               7'h03:   tx_byte = REJECT_LEN;
               7'h04:   tx_byte = XF_REJECT;
               default: tx_byte = rej_code_q;
            endcase
         end
         TX_STATUS: begin
            if (tx_idx_q == 7'h00) tx_byte = PROTO_ID;
            else if (tx_idx_q == 7'h01) tx_byte = CMD_XFER;
            else if (tx_idx_q == 7'h02) tx_byte = 8'h00;
            else if (tx_idx_q == 7'h03) tx_byte = STATUS_LEN;
            else if (tx_idx_q == 7'h04) tx_byte = XF_STAT_R;
            else if (tx_idx_q < TX_PART_POS) tx_byte = hex_char(digest_q[dbase -: 4]);
            else tx_byte = PART_NUMBER[pbase -: 8];
         end
         default: tx_byte = 8'h00;
      endcase
   end
   // reply sequencer; a late reply is dropped and flagged
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || expire) begin
         busy_q   <= 1'b0;
         tx_o     <= '0;
         tx_idx_q <= 7'h00;
      end else if (start) begin
         busy_q   <= 1'b1;
         kind_q   <= st_rej ? TX_REJECT : (st_stat ? TX_STATUS : TX_TEMP);
         tx_n_q   <= st_rej ? TX_N_REJECT : (st_stat ? TX_N_STATUS : TX_N_TEMP);
         tx_idx_q <= 7'h00;
      end else if (busy_q && tx_free) begin
         tx_o     <= '{valid: 1'b1, last: tx_idx_q == 7'(tx_n_q - 7'h01), data: tx_byte};
         tx_idx_q <= 7'(tx_idx_q + 7'h01);
         busy_q   <= tx_idx_q != 7'(tx_n_q - 7'h01);
      end else if (tx_ready_i) begin
         tx_o.valid <= 1'b0;
      end
   end

   // avalon slave: one wait cycle, then the access completes
   wire        acc    = avm_read_i || avm_write_i;
   wire        wr_now = avm_write_i && !avm_waitrequest_o;
   wire [31:0] be_m   = {{8{avm_byteenable_i[3]}}, {8{avm_byteenable_i[2]}},
                         {8{avm_byteenable_i[1]}}, {8{avm_byteenable_i[0]}}};
   wire        w_lim  = wr_now && avm_address_i == REG_LIMITS;
   wire        w_tmo  = wr_now && avm_address_i == REG_TIMEOUT && avm_byteenable_i[0];
   wire        w_tmp  = wr_now && avm_address_i == REG_TEMP && avm_byteenable_i[0];
   wire        w_xfr  = wr_now && avm_address_i == REG_XFER && avm_byteenable_i[0];
   wire [31:0] rd_mux = (avm_address_i == REG_LIMITS)  ? limits_q :
                        (avm_address_i == REG_TIMEOUT) ? {24'h0, timeout_q} :
                        (avm_address_i == REG_TEMP)    ? {24'h0, temp_q} :
                        (avm_address_i == REG_OUTLETS) ?
                           {14'h0, 2'(ind_q), 2'(fan_q), 2'(lamp_q), 3'h0, inh_s2_q,
                            dc_en_q, ac_en_q} :
                        (avm_address_i == REG_XFER)    ?
                           {16'h0, rej_code_q, 3'h0, late_q, flash_bad_q, wait_hash_q,
                            2'(xs_q)} : 32'h0;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         avm_waitrequest_o <= 1'b1;
         avm_readdata_o    <= 32'h0;
      end else begin
         avm_waitrequest_o <= !(avm_waitrequest_o && acc);
         if (avm_waitrequest_o && avm_read_i) avm_readdata_o <= rd_mux;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         limits_q  <= LIMITS_RST;
         timeout_q <= TIMEOUT_RST;
         temp_q    <= TEMP_RST;
         late_q    <= 1'b0;
      end else begin
         if (w_lim) limits_q <= (limits_q & ~be_m) | (avm_writedata_i & be_m);
         if (w_tmo) timeout_q <= avm_writedata_i[7:0];
         if (w_tmp) temp_q <= avm_writedata_i[7:0];
         late_q <= expire || (late_q && !(w_xfr && avm_writedata_i[4]));
      end
   end

endmodule

// ==== seat_power_assertions.sv ====
// port checker for the seat power command handler
// bound by the testbench top file to the design's ports
`timescale 1ns/1ps
module seat_power_checker
   import seat_power_pkg::*;
(
   input wire logic       clk_sys_i, rst_i, avm_read_i, avm_write_i, avm_waitrequest_o,
   input wire logic       rx_err_i, tx_ready_i, outlet_inhibit_i, fan_force_on_o,
   input wire logic       fan_disable_o, ind_green_o, ind_red_o,
   input wire logic [3:0] ac_out_o, dc_out_o,
   input wire byte_beat_s rx_i, tx_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // header of a config message, one beat per cycle
   sequence s_cfg(logic [7:0] len, logic [23:0] tag);
      rx_i == {2'b10, PROTO_ID} ##1 rx_i == {2'b10, CMD_CFG} ##1 rx_i == {2'b10, len} ##1
      rx_i == {2'b10, tag[23:16]} ##1 rx_i == {2'b10, tag[15:8]} ##1 rx_i == {2'b10, tag[7:0]};
   endsequence
   AST_AVM_WAIT: assert property ((avm_read_i || avm_write_i) && avm_waitrequest_o |=>
      !avm_waitrequest_o ##1 avm_waitrequest_o) else $error("bus wait not one cycle");
   AST_TX_HOLD: assert property (tx_o.valid && !tx_ready_i |=> $stable(tx_o))
      else $error("reply byte moved");
   AST_FAN_EXCL: assert property (!(fan_force_on_o && fan_disable_o))
      else $error("fan on and off");
   AST_IND_EXCL: assert property (!(ind_green_o && ind_red_o))
      else $error("indicator green and red");
   AST_INHIBIT: assert property (outlet_inhibit_i [*5] |-> {ac_out_o, dc_out_o} == 8'h00)
      else $error("outlet on while inhibited");
   AST_OUTLET_ON: assert property (s_cfg(LEN_OUTLET, TAG_OUTLET) ##1 rx_i == 10'h255 ##1
      rx_i.valid ##1 rx_i == 10'h355 && !rx_err_i && !outlet_inhibit_i |-> ##2
      {ac_out_o, dc_out_o} == 8'hFF) else $error("outlets not enabled");
   AST_POLICY_OFF: assert property (s_cfg(LEN_POLICY, TAG_POLICY) ##1 rx_i == 10'h303
      && !rx_err_i |-> ##2 {ac_out_o, dc_out_o} == 8'h00) else $error("policy off ignored");
   AST_TEMP_REPLY: assert property (rx_i == 10'h201 ##1 rx_i == 10'h3A5 && !rx_err_i
      && !tx_o.valid |-> ##3 tx_o == 10'h201) else $error("temperature reply late");
endmodule

// ==== node_model.sv ====
// cabin node model: sends request frames, sinks reply bytes
// same clock as the handler; stalls every other cycle when slow
`timescale 1ns/1ps
module node_model
   import seat_power_pkg::*;
(
   input  wire logic       clk_sys_i,
   input  wire byte_beat_s tx_i,
   output logic            tx_ready_o,
   output byte_beat_s      rx_o
);
   logic [7:0] got_q[$];
   logic       slow_q;
   initial {slow_q, tx_ready_o, rx_o} = 12'h400;
   // a byte counts only on valid and ready at one edge
   always @(posedge clk_sys_i) begin
      if (tx_i.valid && tx_ready_o) got_q.push_back(tx_i.data);
      tx_ready_o <= slow_q ? !tx_ready_o : 1'b1;
   end
   // one beat per cycle; the released line shows the inverted last byte
   task automatic send(input logic [7:0] m[$]);
      foreach (m[i]) begin
         @(posedge clk_sys_i);
         rx_o <= '{1'b1, i == m.size() - 1, m[i]};
      end
      @(posedge clk_sys_i);
      rx_o <= '{1'b0, 1'b0, ~m[m.size() - 1]};
   endtask
endmodule

// ==== testbench.sv ====
// self-checking bench for the seat power command handler
// needs package, design, node model and checker compiled first
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_fail++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module testbench import seat_power_pkg::*;;
   logic         clk_sys_i, rst_i, avm_read_i, avm_write_i, rx_err_i, tx_ready_i, hash_done_i;
   logic         outlet_inhibit_i, flash_fail_i, prog_sum_bad_i, coproc_fault_i, hash_req_o;
   logic         avm_waitrequest_o, lamp_force_on_o, fan_force_on_o, fan_disable_o;
   logic         ind_green_o, ind_red_o;
   logic [3:0]   avm_byteenable_i, ac_out_o, dc_out_o;
   logic [4:0]   avm_address_i;
   logic [7:0]   outlet_in_use_i;
   logic [31:0]  avm_writedata_i, avm_readdata_o;
   logic [255:0] digest_i;
   byte_beat_s   rx_i, tx_o, image_chunk_o;
   int           n_fail, samples_checked, cyc;
   wire  [12:0]  outs = {ac_out_o, dc_out_o, lamp_force_on_o, fan_force_on_o, fan_disable_o,
                         ind_green_o, ind_red_o};
   seat_power_command_handler #(.RESP_LIMIT_CYC(1000)) seat_power_command_handler_inst (.*);
   node_model node_model_inst (.clk_sys_i, .tx_i(tx_o), .tx_ready_o(tx_ready_i), .rx_o(rx_i));
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   // hash stand-in answers a cycle late; cycle ceiling cuts a hang
   always @(posedge clk_sys_i) begin
      hash_done_i <= hash_req_o;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         stop_test();
      end
   end
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                      input logic [3:0] be, output logic [31:0] rd);
      @(posedge clk_sys_i);
      {avm_read_i, avm_write_i} <= {!wr, wr};
      {avm_address_i, avm_writedata_i, avm_byteenable_i} <= {a, wd, be};
      do @(posedge clk_sys_i); while (avm_waitrequest_o !== 1'b0);
      rd = avm_readdata_o;
      {avm_read_i, avm_write_i} <= 2'h0;
   endtask
   task automatic msg(input logic [7:0] m[$]);
      node_model_inst.send(m);
      repeat (4) @(negedge clk_sys_i);
   endtask
   task automatic expect_reply(input logic [7:0] e[$]);
      while (node_model_inst.got_q.size() < e.size()) @(posedge clk_sys_i);
      foreach (e[i]) `CHK("reply byte", e[i], node_model_inst.got_q[i])
      node_model_inst.got_q.delete();
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // registers, temperature, outlet codes, inhibit, policy, transfer
   initial begin
      logic [7:0]  e[$];
      logic [31:0] rd;
      logic [23:0] cfgs[4] = '{24'h557255, 24'hFF0000, 24'h9C91AA, 24'h003300};
      logic [12:0] cexp[4] = '{13'h1FF5, 13'h1FF5, 13'h0E0A, 13'h0E04};
      logic [7:0]  pol[3] = '{POLICY_ALL, POLICY_UNUSED, POLICY_NONE};
      logic [7:0]  pexp[3] = '{8'hFF, 8'hF0, 8'h00};
      {rst_i, avm_read_i, avm_write_i, rx_err_i, outlet_inhibit_i} = 5'h10;
      {flash_fail_i, prog_sum_bad_i, coproc_fault_i} = 3'h0;
      {avm_address_i, avm_writedata_i, avm_byteenable_i} = '0;
      {outlet_in_use_i, digest_i} = {8'h0F, 4'hA, 252'h0};
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      bus(1'b0, REG_OUTLETS, 32'h0, 4'hF, rd);
      `CHK("outlet reg", 32'h0, rd)
      bus(1'b0, 5'h14, 32'h0, 4'hF, rd);
      `CHK("unmapped", 32'h0, rd)
      bus(1'b1, REG_LIMITS, 32'h112233FF, 4'hF, rd);
      bus(1'b1, REG_LIMITS, 32'h00000044, 4'h1, rd);
      bus(1'b1, REG_TIMEOUT, 32'h05, 4'h1, rd);
      bus(1'b1, REG_TEMP, 32'h88, 4'h1, rd);
      node_model_inst.slow_q = 1'b1;
      msg('{PROTO_ID, CMD_TEMP_Q});
      e = '{PROTO_ID, CMD_TEMP_R, LEN_TEMP, 8'h11, 8'h22, 8'h33, 8'h44, 8'h05, 8'h88};
      expect_reply(e);
      foreach (cfgs[i]) begin
         msg('{PROTO_ID, CMD_CFG, LEN_OUTLET, 8'h50, 8'h4F, 8'h53,
               cfgs[i][23:16], cfgs[i][15:8], cfgs[i][7:0]});
         `CHK("outputs", cexp[i], outs)
      end
      @(posedge clk_sys_i);
      outlet_inhibit_i <= 1'b1;
      repeat (6) @(negedge clk_sys_i);
      `CHK("inhibited", 8'h00, outs[12:5])
      @(posedge clk_sys_i);
      outlet_inhibit_i <= 1'b0;
      foreach (pol[i]) begin
         msg('{PROTO_ID, CMD_CFG, LEN_POLICY, 8'h50, 8'h4D, 8'h53, pol[i]});
         `CHK("policy", pexp[i], outs[12:5])
      end
      msg('{PROTO_ID, CMD_XFER, 8'h00, 8'h01, XF_DONE});
      expect_reply('{PROTO_ID, CMD_XFER, 8'h00, REJECT_LEN, XF_REJECT, ERR_SEQ});
      node_model_inst.slow_q = 1'b0;
      msg('{PROTO_ID, CMD_XFER, 8'h00, 8'h01, XF_QUERY});
      e = '{PROTO_ID, CMD_XFER, 8'h00, STATUS_LEN, XF_STAT_R, 8'h41};
      repeat (63) e.push_back(8'h30);
      for (int i = 15; i >= 0; i--) e.push_back(PART_DEF[i*8 +: 8]);
      expect_reply(e);
      stop_test();
   end
endmodule
bind seat_power_command_handler seat_power_checker seat_power_checker_inst (.*);
